/* File: hw/gpio_consts.svh */
// register offsets, field positions, widths, reset values and response codes for the pin port block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
// register byte offsets
`define OFS_FIRST_DATA   12'h000
`define OFS_FIRST_DIR    12'h004
`define OFS_SECOND_DATA  12'h008
`define OFS_SECOND_DIR   12'h00C
`define OFS_THIRD_DATA   12'h010
`define OFS_THIRD_DIR    12'h014
`define OFS_PULLUP_OPT   12'h018
`define OFS_KEYSCAN_EN   12'h01C
`define OFS_CONTROL      12'h020
`define OFS_PIN_FIRST    12'h024
`define OFS_PIN_SECOND   12'h028
`define OFS_PIN_THIRD    12'h02C
// field positions
`define PU_FIRST_BIT     0
`define PU_SECOND_BIT    1
`define PU_THIRD_BIT     2
`define CTL_STOP_BIT     0
`define CTL_HCO_BIT      1
// widths, reset values and response codes
`define THIRD_W          5
`define DIR_RESET        8'h00
`define DATA_RESET       8'h00
`define PU_RESET         3'h0
`define KS_RESET         8'h00
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`endif

/* File: hw/gpio_pkg.sv */
// types shared by the pin port block
package gpio_pkg;
	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_RESP = 3'b010,
		WR_HOLD = 3'b100
	} wr_state_t;
	typedef logic [7:0] port_byte_t;
endpackage

/* File: hw/gpio_ports.sv */
// three bidirectional pin ports with direction, pull-up, key scan and stop hold
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports
	import gpio_pkg::*;
(
	input  wire logic                  CLK_I,
	input  wire logic                  SYS_RST_I,
	input  wire logic [11:0]           S_AXI_AWADDR_I,
	input  wire logic                  S_AXI_AWVALID_I,
	output logic                       S_AXI_AWREADY_O,
	input  wire logic [31:0]           S_AXI_WDATA_I,
	input  wire logic [3:0]            S_AXI_WSTRB_I,
	input  wire logic                  S_AXI_WVALID_I,
	output logic                       S_AXI_WREADY_O,
	output logic [1:0]                 S_AXI_BRESP_O,
	output logic                       S_AXI_BVALID_O,
	input  wire logic                  S_AXI_BREADY_I,
	input  wire logic [11:0]           S_AXI_ARADDR_I,
	input  wire logic                  S_AXI_ARVALID_I,
	output logic                       S_AXI_ARREADY_O,
	output logic [31:0]                S_AXI_RDATA_O,
	output logic [1:0]                 S_AXI_RRESP_O,
	output logic                       S_AXI_RVALID_O,
	input  wire logic                  S_AXI_RREADY_I,
	input  wire logic [7:0]            FIRST_PORT_I,
	output logic [7:0]                 FIRST_PORT_O,
	output logic [7:0]                 FIRST_PORT_OE_N_O,
	output logic [7:0]                 FIRST_PORT_PU_O,
	input  wire logic [7:0]            SECOND_PORT_I,
	output logic [7:0]                 SECOND_PORT_O,
	output logic [7:0]                 SECOND_PORT_OE_N_O,
	output logic [7:0]                 SECOND_PORT_PU_O,
	input  wire logic [`THIRD_W-1:0]   THIRD_PORT_I,
	output logic [`THIRD_W-1:0]        THIRD_PORT_O,
	output logic [`THIRD_W-1:0]        THIRD_PORT_OE_N_O,
	output logic [`THIRD_W-1:0]        THIRD_PORT_PU_O,
	input  wire logic                  RESET_PIN_N_I,
	output logic                       RESET_PIN_PU_O,
	output logic                       CTRL_RESET_O,
	output logic                       HIGH_CURRENT_OUT_O,
	output logic [7:0]                 KEY_SCAN_O,
	output logic                       EXT_IRQ_IN_ONE_O,
	output logic                       EXT_IRQ_IN_TWO_O,
	output logic                       EVENT_COUNT_IN_O,
	output logic                       TIMER_ZERO_PIN_O,
	output logic                       TIMER_ONE_PIN_O,
	output logic                       TIMER_TWO_PIN_O
);

	// ****************************************************
	// pin input synchronisers
	// ****************************************************
	port_byte_t                first_s1_q, first_s2_q;
	port_byte_t                second_s1_q, second_s2_q;
	logic [`THIRD_W-1:0]       third_s1_q, third_s2_q;
	logic                      rst_s1_q, rst_s2_q;

	// two flops on every pin; the first stage is read only by the second
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			first_s1_q  <= 8'h00;
			first_s2_q  <= 8'h00;
			second_s1_q <= 8'h00;
			second_s2_q <= 8'h00;
			third_s1_q  <= '0;
			third_s2_q  <= '0;
			rst_s1_q    <= 1'b1;
			rst_s2_q    <= 1'b1;
		end else begin
			first_s1_q  <= FIRST_PORT_I;
			first_s2_q  <= first_s1_q;
			second_s1_q <= SECOND_PORT_I;
			second_s2_q <= second_s1_q;
			third_s1_q  <= THIRD_PORT_I;
			third_s2_q  <= third_s1_q;
			rst_s1_q    <= RESET_PIN_N_I;
			rst_s2_q    <= rst_s1_q;
		end
	end

	// ****************************************************
	// software registers
	// ****************************************************
	port_byte_t                first_data_q, first_dir_q;
	port_byte_t                second_data_q, second_dir_q;
	logic [`THIRD_W-1:0]       third_data_q, third_dir_q;
	logic [2:0]                pu_opt_q;
	port_byte_t                keyscan_q;
	logic                      stop_q, hco_q;

	// byte-lane merge of write data into a register
	function automatic port_byte_t lane_merge(input port_byte_t old,
		input logic [31:0] wd, input logic [3:0] st);
		lane_merge = st[0] ? wd[7:0] : old;
	endfunction

	// ****************************************************
	// axi4-lite write channel
	// ****************************************************
	wr_state_t                 wr_q;
	logic                      aw_got_q, w_got_q;
	logic [11:0]               awaddr_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;
	logic                      wr_fire;
	logic                      wr_hit;

	assign wr_fire = (wr_q == WR_IDLE) && aw_got_q && w_got_q;

	// address and data are taken in either order, the response follows both
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wr_q            <= WR_IDLE;
			aw_got_q        <= 1'b0;
			w_got_q         <= 1'b0;
			awaddr_q        <= 12'h000;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= `AXI_OKAY;
		end else begin
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			case (wr_q)
				WR_IDLE: begin
					if (S_AXI_AWVALID_I && !aw_got_q && !S_AXI_AWREADY_O) begin
						S_AXI_AWREADY_O <= 1'b1;
						awaddr_q        <= S_AXI_AWADDR_I;
						aw_got_q        <= 1'b1;
					end
					if (S_AXI_WVALID_I && !w_got_q && !S_AXI_WREADY_O) begin
						S_AXI_WREADY_O <= 1'b1;
						wdata_q        <= S_AXI_WDATA_I;
						wstrb_q        <= S_AXI_WSTRB_I;
						w_got_q        <= 1'b1;
					end
					if (wr_fire) begin
						wr_q           <= WR_RESP;
						S_AXI_BVALID_O <= 1'b1;
						S_AXI_BRESP_O  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
					end
				end
				WR_RESP: begin
					if (S_AXI_BREADY_I) begin
						S_AXI_BVALID_O <= 1'b0;
						aw_got_q       <= 1'b0;
						w_got_q        <= 1'b0;
						wr_q           <= WR_HOLD;
					end
				end
				WR_HOLD: begin
					wr_q <= WR_IDLE;
				end
				default: begin
					wr_q <= WR_IDLE;
				end
			endcase
		end
	end

	// decode of the write address
	always_comb begin
		if (awaddr_q == `OFS_FIRST_DATA || awaddr_q == `OFS_FIRST_DIR) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == `OFS_SECOND_DATA || awaddr_q == `OFS_SECOND_DIR) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == `OFS_THIRD_DATA || awaddr_q == `OFS_THIRD_DIR) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == `OFS_PULLUP_OPT || awaddr_q == `OFS_KEYSCAN_EN) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == `OFS_CONTROL) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// register updates; reset leaves every pin an input
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			first_data_q  <= `DATA_RESET;
			first_dir_q   <= `DIR_RESET;
			second_data_q <= `DATA_RESET;
			second_dir_q  <= `DIR_RESET;
			third_data_q  <= '0;
			third_dir_q   <= '0;
			pu_opt_q      <= `PU_RESET;
			keyscan_q     <= `KS_RESET;
			stop_q        <= 1'b0;
			hco_q         <= 1'b0;
		end else if (wr_fire) begin
			if (awaddr_q == `OFS_FIRST_DATA) begin
				first_data_q <= lane_merge(first_data_q, wdata_q, wstrb_q);
			end else if (awaddr_q == `OFS_FIRST_DIR) begin
				first_dir_q <= lane_merge(first_dir_q, wdata_q, wstrb_q);
			end else if (awaddr_q == `OFS_SECOND_DATA) begin
				second_data_q <= lane_merge(second_data_q, wdata_q, wstrb_q);
			end else if (awaddr_q == `OFS_SECOND_DIR) begin
				second_dir_q <= lane_merge(second_dir_q, wdata_q, wstrb_q);
			end else if (awaddr_q == `OFS_THIRD_DATA) begin
				third_data_q <= wstrb_q[0] ? wdata_q[`THIRD_W-1:0] : third_data_q;
			end else if (awaddr_q == `OFS_THIRD_DIR) begin
				third_dir_q <= wstrb_q[0] ? wdata_q[`THIRD_W-1:0] : third_dir_q;
			end else if (awaddr_q == `OFS_PULLUP_OPT) begin
				pu_opt_q <= wstrb_q[0] ? wdata_q[2:0] : pu_opt_q;
			end else if (awaddr_q == `OFS_KEYSCAN_EN) begin
				keyscan_q <= lane_merge(keyscan_q, wdata_q, wstrb_q);
			end else if (awaddr_q == `OFS_CONTROL) begin
				stop_q <= wstrb_q[0] ? wdata_q[`CTL_STOP_BIT] : stop_q;
				hco_q  <= wstrb_q[0] ? wdata_q[`CTL_HCO_BIT] : hco_q;
			end
		end
	end

	// ****************************************************
	// axi4-lite read channel
	// ****************************************************
	logic [31:0]               rd_val;

	// read decode; unmapped addresses answer zero with slverr
	always_comb begin
		rd_val = 32'h0000_0000;
		if (S_AXI_ARADDR_I == `OFS_FIRST_DATA) begin
			rd_val[7:0] = first_data_q;
		end else if (S_AXI_ARADDR_I == `OFS_FIRST_DIR) begin
			rd_val[7:0] = first_dir_q;
		end else if (S_AXI_ARADDR_I == `OFS_SECOND_DATA) begin
			rd_val[7:0] = second_data_q;
		end else if (S_AXI_ARADDR_I == `OFS_SECOND_DIR) begin
			rd_val[7:0] = second_dir_q;
		end else if (S_AXI_ARADDR_I == `OFS_THIRD_DATA) begin
			rd_val[`THIRD_W-1:0] = third_data_q;
		end else if (S_AXI_ARADDR_I == `OFS_THIRD_DIR) begin
			rd_val[`THIRD_W-1:0] = third_dir_q;
		end else if (S_AXI_ARADDR_I == `OFS_PULLUP_OPT) begin
			rd_val[2:0] = pu_opt_q;
		end else if (S_AXI_ARADDR_I == `OFS_KEYSCAN_EN) begin
			rd_val[7:0] = keyscan_q;
		end else if (S_AXI_ARADDR_I == `OFS_CONTROL) begin
			rd_val[`CTL_STOP_BIT] = stop_q;
			rd_val[`CTL_HCO_BIT]  = hco_q;
		end else if (S_AXI_ARADDR_I == `OFS_PIN_FIRST) begin
			rd_val[7:0] = first_s2_q;
		end else if (S_AXI_ARADDR_I == `OFS_PIN_SECOND) begin
			rd_val[7:0] = second_s2_q;
		end else if (S_AXI_ARADDR_I == `OFS_PIN_THIRD) begin
			rd_val[`THIRD_W-1:0] = third_s2_q;
		end
	end

	// one read at a time: arready pulses, rvalid holds until rready
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= 32'h0000_0000;
			S_AXI_RRESP_O   <= `AXI_OKAY;
		end else begin
			S_AXI_ARREADY_O <= 1'b0;
			if (S_AXI_RVALID_O) begin
				if (S_AXI_RREADY_I) begin
					S_AXI_RVALID_O <= 1'b0;
				end
			end else if (S_AXI_ARVALID_I && !S_AXI_ARREADY_O) begin
				S_AXI_ARREADY_O <= 1'b1;
				S_AXI_RVALID_O  <= 1'b1;
				S_AXI_RDATA_O   <= rd_val;
				S_AXI_RRESP_O   <= (S_AXI_ARADDR_I > `OFS_PIN_THIRD ||
					S_AXI_ARADDR_I[1:0] != 2'b00) ? `AXI_SLVERR : `AXI_OKAY;
			end
		end
	end

	// ****************************************************
	// pin drivers
	// ****************************************************
	// stop freezes the port pins: registers may change but port pins keep their level; high-current out goes low
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			FIRST_PORT_O       <= 8'h00;
			FIRST_PORT_OE_N_O  <= 8'hFF;
			FIRST_PORT_PU_O    <= 8'h00;
			SECOND_PORT_O      <= 8'h00;
			SECOND_PORT_OE_N_O <= 8'hFF;
			SECOND_PORT_PU_O   <= 8'h00;
			THIRD_PORT_O       <= '0;
			THIRD_PORT_OE_N_O  <= '1;
			THIRD_PORT_PU_O    <= '0;
			HIGH_CURRENT_OUT_O <= 1'b0;
		end else begin
			if (!stop_q) begin
				FIRST_PORT_O       <= first_data_q;
				FIRST_PORT_OE_N_O  <= ~first_dir_q;
				FIRST_PORT_PU_O    <= {8{pu_opt_q[`PU_FIRST_BIT]}} & ~first_dir_q;
				SECOND_PORT_O      <= second_data_q;
				SECOND_PORT_OE_N_O <= ~second_dir_q;
				SECOND_PORT_PU_O   <= {8{pu_opt_q[`PU_SECOND_BIT]}} & ~second_dir_q;
				THIRD_PORT_O       <= third_data_q;
				THIRD_PORT_OE_N_O  <= ~third_dir_q;
				THIRD_PORT_PU_O    <= {`THIRD_W{pu_opt_q[`PU_THIRD_BIT]}} & ~third_dir_q;
			end
			HIGH_CURRENT_OUT_O <= hco_q && !stop_q;
		end
	end

	// ****************************************************
	// alternate functions and reset pin
	// ****************************************************
	// pin level goes to the consumers whatever the direction
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			KEY_SCAN_O       <= 8'h00;
			EXT_IRQ_IN_ONE_O <= 1'b0;
			EXT_IRQ_IN_TWO_O <= 1'b0;
			EVENT_COUNT_IN_O <= 1'b0;
			TIMER_TWO_PIN_O  <= 1'b0;
			TIMER_ONE_PIN_O  <= 1'b0;
			TIMER_ZERO_PIN_O <= 1'b0;
			RESET_PIN_PU_O   <= 1'b1;
			CTRL_RESET_O     <= 1'b1;
		end else begin
			KEY_SCAN_O       <= ~first_s2_q & keyscan_q;
			EXT_IRQ_IN_ONE_O <= second_s2_q[1];
			EXT_IRQ_IN_TWO_O <= second_s2_q[2];
			EVENT_COUNT_IN_O <= second_s2_q[4];
			TIMER_TWO_PIN_O  <= second_s2_q[5];
			TIMER_ONE_PIN_O  <= second_s2_q[6];
			TIMER_ZERO_PIN_O <= second_s2_q[7];
			RESET_PIN_PU_O   <= 1'b1;
			CTRL_RESET_O     <= ~rst_s2_q;
		end
	end

endmodule // gpio_ports

/* File: testbench/board_pins.sv */
// board circuitry on one pin port: external drivers, pull-ups, open pins
`timescale 1ns/1ps
module board_pins #(parameter int W = 8) (
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] pu_i,
	input  wire logic [W-1:0] ext_val_i,
	input  wire logic [W-1:0] ext_en_i,
	input  wire logic         clk_i,
	output logic      [W-1:0] pin_o
);
	// ****
	// wire level
	// ****
	logic [W-1:0] float_q = '0;
	// an open pin flips every cycle so no stale level can pass for a real one
	always_ff @(posedge clk_i) float_q <= ~float_q;
	// device drive wins, then the board driver, then the pull-up
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (!oe_n_i[b]) pin_o[b] = out_i[b];
			else if (ext_en_i[b]) pin_o[b] = ext_val_i[b];
			else pin_o[b] = pu_i[b] | float_q[b];
		end
	end
endmodule // board_pins

/* File: testbench/gpio_ports_chk.sv */
// port-level checker for the pin port block
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports_chk (
	input wire logic                CLK_I,
	input wire logic                SYS_RST_I,
	input wire logic                S_AXI_BVALID_O,
	input wire logic                S_AXI_BREADY_I,
	input wire logic [7:0]          FIRST_PORT_I,
	input wire logic [7:0]          SECOND_PORT_I,
	input wire logic [7:0]          FIRST_PORT_OE_N_O,
	input wire logic [7:0]          SECOND_PORT_OE_N_O,
	input wire logic [`THIRD_W-1:0] THIRD_PORT_OE_N_O,
	input wire logic [7:0]          FIRST_PORT_PU_O,
	input wire logic [7:0]          SECOND_PORT_PU_O,
	input wire logic [`THIRD_W-1:0] THIRD_PORT_PU_O,
	input wire logic                RESET_PIN_N_I,
	input wire logic                RESET_PIN_PU_O,
	input wire logic                CTRL_RESET_O,
	input wire logic [7:0]          KEY_SCAN_O,
	input wire logic                EXT_IRQ_IN_ONE_O,
	input wire logic                EXT_IRQ_IN_TWO_O,
	input wire logic                EVENT_COUNT_IN_O,
	input wire logic                TIMER_ZERO_PIN_O,
	input wire logic                TIMER_ONE_PIN_O,
	input wire logic                TIMER_TWO_PIN_O
);
	// ****
	// properties
	// ****
	logic [2:0] up_q;
	// pin paths need three edges of history after reset before they can be compared
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	property p_pu_off;
		((FIRST_PORT_PU_O & ~FIRST_PORT_OE_N_O) == 8'h00) &&
		((SECOND_PORT_PU_O & ~SECOND_PORT_OE_N_O) == 8'h00) &&
		((THIRD_PORT_PU_O & ~THIRD_PORT_OE_N_O) == '0);
	endproperty
	property p_oe_rst;
		$fell(SYS_RST_I) |-> &{FIRST_PORT_OE_N_O, SECOND_PORT_OE_N_O, THIRD_PORT_OE_N_O};
	endproperty
	// direction only moves after a register write has been answered
	property p_oe_cause;
		$changed({FIRST_PORT_OE_N_O, SECOND_PORT_OE_N_O, THIRD_PORT_OE_N_O})
			|-> $past(S_AXI_BVALID_O) || $past(S_AXI_BVALID_O, 2);
	endproperty
	property p_rst_pu; RESET_PIN_PU_O; endproperty
	property p_ctl_lo; !RESET_PIN_N_I [*4] |-> CTRL_RESET_O; endproperty
	property p_ctl_hi; RESET_PIN_N_I [*5] |-> !CTRL_RESET_O; endproperty
	property p_irq;
		up_q == 3'h7 |-> {EXT_IRQ_IN_TWO_O, EXT_IRQ_IN_ONE_O} == $past(SECOND_PORT_I[2:1], 3);
	endproperty
	property p_ec; up_q == 3'h7 |-> EVENT_COUNT_IN_O == $past(SECOND_PORT_I[4], 3); endproperty
	property p_tmr;
		up_q == 3'h7 |-> {TIMER_ZERO_PIN_O, TIMER_ONE_PIN_O, TIMER_TWO_PIN_O}
			== $past(SECOND_PORT_I[7:5], 3);
	endproperty
	property p_key; up_q == 3'h7 |-> (KEY_SCAN_O & $past(FIRST_PORT_I, 3)) == 8'h00; endproperty
	property p_bhold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O; endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull-up on driven pin");
	a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
	a_oe_cause: assert property (p_oe_cause) else $error("direction moved unasked");
	a_rst_pu: assert property (p_rst_pu) else $error("reset pin pull-up off");
	a_ctl_lo: assert property (p_ctl_lo) else $error("reset not raised");
	a_ctl_hi: assert property (p_ctl_hi) else $error("reset stuck high");
	a_irq: assert property (p_irq) else $error("interrupt input wrong");
	a_ec: assert property (p_ec) else $error("event input wrong");
	a_tmr: assert property (p_tmr) else $error("timer pins wrong");
	a_key: assert property (p_key) else $error("key scan on high pin");
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");
	c_drive: cover property (FIRST_PORT_OE_N_O != 8'hFF);
	c_key: cover property (KEY_SCAN_O != 8'h00);
	c_ctl: cover property (CTRL_RESET_O && up_q == 3'h7);
endmodule // gpio_ports_chk
bind gpio_ports gpio_ports_chk i_chk (.CLK_I, .SYS_RST_I, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
	.FIRST_PORT_I, .SECOND_PORT_I, .FIRST_PORT_OE_N_O, .SECOND_PORT_OE_N_O,
	.THIRD_PORT_OE_N_O, .FIRST_PORT_PU_O, .SECOND_PORT_PU_O, .THIRD_PORT_PU_O,
	.RESET_PIN_N_I, .RESET_PIN_PU_O, .CTRL_RESET_O, .KEY_SCAN_O, .EXT_IRQ_IN_ONE_O,
	.EXT_IRQ_IN_TWO_O, .EVENT_COUNT_IN_O, .TIMER_ZERO_PIN_O, .TIMER_ONE_PIN_O,
	.TIMER_TWO_PIN_O);

/* File: testbench/tb_top.sv */
// self-checking bench for the pin port block
`timescale 1ns/1ps
`include "gpio_consts.svh"
module tb_top
	import gpio_pkg::*;
;
	// ****
	// signals
	// ****
	logic                clk = 1'b0, rst = 1'b1, rpin_n = 1'b1;
	logic [11:0]         awaddr = '0, araddr = '0;
	logic [31:0]         wdata = '0, rdata, rv;
	logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                arvalid = 1'b0, rready = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid, rpu, crst, hco;
	logic                irq1, irq2, ec, t0, t1, t2;
	logic [1:0]          bresp, rresp, resp;
	port_byte_t          pin1, out1, oe1, pu1, pin2, out2, oe2, pu2, ks;
	port_byte_t          ext1 = '0, en1 = '0, ext2 = '0, en2 = '0;
	logic [`THIRD_W-1:0] pin3, out3, oe3, pu3;
	int                  err_count = 0, compares = 0;
	localparam port_byte_t PATS [4] = '{8'h12, 8'hED, 8'hA0, 8'h5F};
	always #5 clk = ~clk;
	gpio_ports i_dut (.CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .FIRST_PORT_I(pin1), .FIRST_PORT_O(out1),
		.FIRST_PORT_OE_N_O(oe1), .FIRST_PORT_PU_O(pu1), .SECOND_PORT_I(pin2),
		.SECOND_PORT_O(out2), .SECOND_PORT_OE_N_O(oe2), .SECOND_PORT_PU_O(pu2),
		.THIRD_PORT_I(pin3), .THIRD_PORT_O(out3), .THIRD_PORT_OE_N_O(oe3),
		.THIRD_PORT_PU_O(pu3), .RESET_PIN_N_I(rpin_n), .RESET_PIN_PU_O(rpu),
		.CTRL_RESET_O(crst), .HIGH_CURRENT_OUT_O(hco), .KEY_SCAN_O(ks),
		.EXT_IRQ_IN_ONE_O(irq1), .EXT_IRQ_IN_TWO_O(irq2), .EVENT_COUNT_IN_O(ec),
		.TIMER_ZERO_PIN_O(t0), .TIMER_ONE_PIN_O(t1), .TIMER_TWO_PIN_O(t2));
	board_pins #(.W(8)) i_b1 (.clk_i(clk), .out_i(out1), .oe_n_i(oe1), .pu_i(pu1),
		.ext_val_i(ext1), .ext_en_i(en1), .pin_o(pin1));
	board_pins #(.W(8)) i_b2 (.clk_i(clk), .out_i(out2), .oe_n_i(oe2), .pu_i(pu2),
		.ext_val_i(ext2), .ext_en_i(en2), .pin_o(pin2));
	board_pins #(.W(`THIRD_W)) i_b3 (.clk_i(clk), .out_i(out3), .oe_n_i(oe3), .pu_i(pu3),
		.ext_val_i('0), .ext_en_i('0), .pin_o(pin3));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// valids drop only at the edge where their ready was seen high
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic aw, w, v;
		n = 0;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge clk); aw = awready; w = wready; v = bvalid; resp = bresp;
			@(posedge clk); n++;
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!v && n < 50);
		bready <= 1'b0;
		// one edge between calls so no handshake signal is assigned twice in a step
		@(posedge clk);
		if (!v) begin err_count++; test_done(); end
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		logic ar, v;
		n = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(negedge clk); ar = arready; v = rvalid; rv = rdata; resp = rresp;
			@(posedge clk); n++;
			if (ar) arvalid <= 1'b0;
		end while (!v && n < 50);
		rready <= 1'b0;
		// the next request starts only after this edge has passed
		@(posedge clk);
		if (!v) begin err_count++; test_done(); end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		rd(a); chk(rv, d); chk(resp, r);
	endtask
	// pin outputs trail the register by one edge, inputs by three
	task automatic settle; repeat (5) @(posedge clk); endtask
	// ****
	// scenarios
	// ****
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({oe1, oe2, oe3}, {8'hFF, 8'hFF, 5'h1F});
		rdchk(`OFS_SECOND_DIR, 32'h0000_0000, `AXI_OKAY);
		chk(rpu, 1'b1);
		for (int p = 0; p < 3; p++) begin
			wr(`OFS_FIRST_DIR + 12'(8 * p), 32'h0000_00A5);
			wr(`OFS_FIRST_DATA + 12'(8 * p), 32'h0000_003C);
		end
		settle();
		chk({oe1, oe2, oe3}, {8'h5A, 8'h5A, 5'h1A});
		chk({out1 & 8'hA5, out2 & 8'hA5, out3 & 5'h05}, {8'h24, 8'h24, 5'h04});
		wr(`OFS_PULLUP_OPT, 32'h0000_0007); settle();
		chk({pu1, pu3}, {8'h5A, 5'h1A});
		rdchk(`OFS_PIN_FIRST, 32'h0000_007E, `AXI_OKAY);
		wr(`OFS_PULLUP_OPT, 32'h0000_0002); wr(`OFS_SECOND_DIR, 32'h0000_0000); settle();
		chk({pu1, pu2}, {8'h00, 8'hFF});
		// each alternate-use second-port pin (bits 1, 2 and 4 to 7) toggles both ways through its alternate use
		for (int i = 0; i < 4; i++) begin
			ext2 <= PATS[i]; en2 <= 8'hFF; settle();
			chk({irq2, irq1}, PATS[i][2:1]);
			chk(ec, PATS[i][4]);
			chk({t0, t1, t2}, PATS[i][7:5]);
		end
		wr(`OFS_FIRST_DIR, 32'h0000_0000); wr(`OFS_KEYSCAN_EN, 32'h0000_000F);
		ext1 <= 8'h5A; en1 <= 8'hFF; settle();
		chk(ks, 8'h05);
		wr(`OFS_KEYSCAN_EN, 32'h0000_00F0); settle();
		chk(ks, 8'hA0);
		wr(`OFS_FIRST_DIR, 32'h0000_00FF); wr(`OFS_FIRST_DATA, 32'h0000_0081);
		wr(`OFS_CONTROL, 32'h0000_0002); settle();
		chk(hco, 1'b1);
		// writes made in stop must not reach the pins until stop ends
		wr(`OFS_CONTROL, 32'h0000_0003); wr(`OFS_FIRST_DATA, 32'h0000_007E);
		wr(`OFS_FIRST_DIR, 32'h0000_000F); settle();
		chk({hco, out1, oe1}, {1'b0, 8'h81, 8'h00});
		wr(`OFS_CONTROL, 32'h0000_0000); settle();
		chk({out1 & 8'h0F, oe1}, {8'h0E, 8'hF0});
		wr(12'h030, 32'h0000_0001); chk(resp, `AXI_SLVERR);
		wr(`OFS_PIN_FIRST, 32'h0000_0001); chk(resp, `AXI_SLVERR);
		rdchk(12'h030, 32'h0000_0000, `AXI_SLVERR);
		rdchk(12'h002, 32'h0000_0000, `AXI_SLVERR);
		rpin_n <= 1'b0; settle();
		chk(crst, 1'b1);
		rpin_n <= 1'b1; settle();
		chk(crst, 1'b0);
		rst <= 1'b1; repeat (2) @(posedge clk); rst <= 1'b0; @(posedge clk);
		chk(oe1, 8'hFF);
		rdchk(`OFS_FIRST_DIR, 32'h0000_0000, `AXI_OKAY);
		test_done();
	end
endmodule // tb_top
